// *** verilog/duart_regs.sv ***
// Register bank of the dual channel serial controller
`timescale 1ns/1ps
module duart_regs
  import duart_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           srst_i,
  input  wire logic [3:0]     addr_i,
  input  wire logic           rd_i,
  input  wire logic           wr_i,
  input  wire logic [7:0]     wdata_i,
  output logic      [7:0]     rdata_o,
  input  wire duart_chan_in_t chan_a_i,
  input  wire duart_chan_in_t chan_b_i,
  input  wire logic           ctr_ready_i,
  input  wire logic [1:0]     break_chg_i,
  input  wire logic [7:0]     in_pin_i,
  output logic      [7:0]     out_pin_o,
  output logic      [7:0]     out_config_o,
  output logic      [15:0]    timer_div_o,
  output logic      [7:0]     aux_control_o,
  output logic      [7:0]     irq_flags_o,
  output logic      [1:0]     rx_en_o,
  output logic      [1:0]     tx_en_o,
  output logic      [1:0]     rx_pop_o,
  output logic      [1:0]     tx_push_o,
  output logic      [7:0]     mode_zero_a_o,
  output logic      [7:0]     mode_zero_b_o,
  output logic      [7:0]     mode_one_a_o,
  output logic      [7:0]     mode_one_b_o,
  output logic      [7:0]     mode_two_a_o,
  output logic      [7:0]     mode_two_b_o,
  output logic      [7:0]     clock_select_a_o,
  output logic      [7:0]     clock_select_b_o
);

  //================================================================
  // Decode
  logic [7:0] mode_zero [2];
  logic [7:0] mode_one  [2];
  logic [7:0] mode_two  [2];
  logic [1:0] mode_ptr  [2];
  logic [6:0] wd_count  [2];
  logic [1:0] wd_fired;
  logic [7:0] irq_mask;
  logic [3:0] in_prev;
  logic [3:0] in_delta;
  logic [1:0] rx_thr_met;
  duart_chan_in_t chan [2];
  logic [3:0] a_mode [2];
  logic [3:0] a_cmd  [2];
  logic [3:0] a_fifo [2];
  logic [3:0] a_stat [2];

  assign chan[0]   = chan_a_i;
  assign chan[1]   = chan_b_i;
  assign a_mode[0] = A_MODE_A;
  assign a_mode[1] = A_MODE_B;
  assign a_cmd[0]  = A_CMD_A;
  assign a_cmd[1]  = A_CMD_B;
  assign a_fifo[0] = A_FIFO_A;
  assign a_fifo[1] = A_FIFO_B;
  assign a_stat[0] = A_STAT_A;
  assign a_stat[1] = A_STAT_B;

  // Threshold lookup; code is split over two mode registers
  function automatic logic [4:0] thr_bytes(input logic [7:0] mz,
                                           input logic [7:0] mo);
    logic [1:0] code;
    code = {mz[MZ_RXTHR], mo[MO_RXTHR]};
    case (code)
      2'd0:    thr_bytes = mz[MZ_DEPTH] ? THR16_0 : THR8_0;
      2'd1:    thr_bytes = mz[MZ_DEPTH] ? THR16_1 : THR8_1;
      2'd2:    thr_bytes = mz[MZ_DEPTH] ? THR16_2 : THR8_2;
      default: thr_bytes = mz[MZ_DEPTH] ? THR16_3 : THR8_3;
    endcase
  endfunction

  //================================================================
  // Per-channel mode, command and watchdog logic
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic mode_hit;
    logic cmd_hit;
    logic fifo_hit;
    assign mode_hit = (rd_i | wr_i) & (addr_i == a_mode[c]);
    assign cmd_hit  = wr_i & (addr_i == a_cmd[c]);
    assign fifo_hit = (rd_i | wr_i) & (addr_i == a_fifo[c]);

    // Mode writes land where the pointer points
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        mode_zero[c] <= RST_BYTE;
        mode_one[c]  <= RST_BYTE;
        mode_two[c]  <= RST_BYTE;
      end else if (mode_hit && wr_i) begin
        case (mode_ptr[c])
          PTR_ZERO: mode_zero[c] <= wdata_i;
          PTR_ONE:  mode_one[c]  <= wdata_i;
          default:  mode_two[c]  <= wdata_i;
        endcase
      end
    end

    // Pointer: commands win over the access increment
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        mode_ptr[c] <= PTR_ONE;
      end else if (cmd_hit && wdata_i[7:4] == CMD_PTR0) begin
        mode_ptr[c] <= PTR_ZERO;
      end else if (cmd_hit && wdata_i[7:4] == CMD_PTR1) begin
        mode_ptr[c] <= PTR_ONE;
      end else if (mode_hit && mode_ptr[c] != PTR_TWO) begin
        mode_ptr[c] <= mode_ptr[c] + 2'd1;
      end
    end

    // Enable bits; disable wins if both are written at once
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        rx_en_o[c] <= 1'b0;
        tx_en_o[c] <= 1'b0;
      end else if (cmd_hit) begin
        if (wdata_i[CMD_RXDIS]) begin
          rx_en_o[c] <= 1'b0;
        end else if (wdata_i[CMD_RXEN]) begin
          rx_en_o[c] <= 1'b1;
        end
        if (wdata_i[CMD_TXDIS]) begin
          tx_en_o[c] <= 1'b0;
        end else if (wdata_i[CMD_TXEN]) begin
          tx_en_o[c] <= 1'b1;
        end
      end
    end

    // FIFO strobes to the serial engine
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        rx_pop_o[c]  <= 1'b0;
        tx_push_o[c] <= 1'b0;
      end else begin
        rx_pop_o[c]  <= fifo_hit & rd_i;
        tx_push_o[c] <= fifo_hit & wr_i;
      end
    end

    // Idle watchdog; only counts while data waits unread
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        wd_count[c] <= '0;
        wd_fired[c] <= 1'b0;
      end else if (fifo_hit || !mode_zero[c][MZ_WDOG]
                   || chan[c].rx_count == '0) begin
        wd_count[c] <= '0;
        wd_fired[c] <= 1'b0;
      end else if (chan[c].rx_bit_tick && !wd_fired[c]) begin
        if (wd_count[c] == WDOG_BITS - 7'd1) begin
          wd_fired[c] <= 1'b1;
        end
        wd_count[c] <= wd_count[c] + 7'd1;
      end
    end

    assign rx_thr_met[c] = (chan[c].rx_count
                            >= thr_bytes(mode_zero[c], mode_one[c]))
                           | wd_fired[c];

    // Request-to-send for pin c is applied in the output port block: mode one bit 7 drops it
    // while the receive FIFO is full; the host set/clear path still steers it otherwise.
  end

  //================================================================
  // Shared write registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_mask         <= RST_BYTE;
      aux_control_o    <= RST_BYTE;
      out_config_o     <= RST_BYTE;
      timer_div_o      <= '0;
      clock_select_a_o <= RST_BYTE;
      clock_select_b_o <= RST_BYTE;
    end else if (wr_i) begin
      case (addr_i)
        A_FLAG_MSK: irq_mask         <= wdata_i;
        A_CHG_AUX:  aux_control_o    <= wdata_i;
        A_LVL_CFG:  out_config_o     <= wdata_i;
        A_TPH:      timer_div_o[15:8] <= wdata_i;
        A_TPL:      timer_div_o[7:0]  <= wdata_i;
        A_STAT_A:   clock_select_a_o <= wdata_i;
        A_STAT_B:   clock_select_b_o <= wdata_i;
        default: ;
      endcase
    end
  end

  // Output port; rts pins drop while receiver FIFO is full
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_pin_o <= RST_BYTE;
    end else begin
      if (wr_i && addr_i == A_OSET) begin
        out_pin_o <= out_pin_o | wdata_i;
      end else if (wr_i && addr_i == A_OCLR) begin
        out_pin_o <= out_pin_o & ~wdata_i;
      end
      for (int c = 0; c < 2; c++) begin
        if (mode_one[c][MO_RXRTS] && chan[c].rx_count
            == (mode_zero[c][MZ_DEPTH] ? THR16_3 : THR8_3)) begin
          out_pin_o[c] <= 1'b0;
        end
      end
    end
  end

  // Input change detect; a new edge beats the read clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      in_prev  <= in_pin_i[3:0];  // No false change flagged after reset
      in_delta <= '0;
    end else begin
      in_prev  <= in_pin_i[3:0];
      in_delta <= ((rd_i && addr_i == A_CHG_AUX) ? 4'h0 : in_delta)
                  | (in_pin_i[3:0] ^ in_prev);
    end
  end

  //================================================================
  // Interrupt flags and read data
  logic [7:0] next_flags;
  always_comb begin
    next_flags          = '0;
    next_flags[FL_TX_A] = chan_a_i.tx_ready;
    next_flags[FL_RX_A] = rx_thr_met[0];
    next_flags[2]       = break_chg_i[0];
    next_flags[3]       = ctr_ready_i;
    next_flags[FL_TX_B] = chan_b_i.tx_ready;
    next_flags[FL_RX_B] = rx_thr_met[1];
    next_flags[6]       = break_chg_i[1];
    next_flags[FL_CHG]  = |(in_delta & aux_control_o[3:0]);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_flags_o <= RST_BYTE;
    end else begin
      irq_flags_o <= next_flags & irq_mask;
    end
  end

  // Status byte per channel
  function automatic logic [7:0] stat_byte(input duart_chan_in_t ch,
                                           input logic wd,
                                           input logic [7:0] mz);
    logic [4:0] depth;
    depth = mz[MZ_DEPTH] ? THR16_3 : THR8_3;
    stat_byte = {ch.errs, ch.tx_empty, ch.tx_ready,
                 ch.rx_count == depth,
                 (ch.rx_count != '0) | wd};
  endfunction

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= RST_BYTE;
    end else if (rd_i) begin
      case (addr_i)
        A_MODE_A: rdata_o <= mode_ptr[0] == PTR_ZERO ? mode_zero[0] :
                             mode_ptr[0] == PTR_ONE  ? mode_one[0] :
                             mode_two[0];
        A_MODE_B: rdata_o <= mode_ptr[1] == PTR_ZERO ? mode_zero[1] :
                             mode_ptr[1] == PTR_ONE  ? mode_one[1] :
                             mode_two[1];
        A_STAT_A: rdata_o <= stat_byte(chan_a_i, wd_fired[0],
                                       mode_zero[0]);
        A_STAT_B: rdata_o <= stat_byte(chan_b_i, wd_fired[1],
                                       mode_zero[1]);
        A_CHG_AUX:  rdata_o <= {in_delta, in_pin_i[3:0]};
        A_FLAG_MSK: rdata_o <= next_flags;
        A_LVL_CFG:  rdata_o <= in_pin_i;
        default:    rdata_o <= RST_BYTE;
      endcase
    end
  end

  assign mode_zero_a_o = mode_zero[0];
  assign mode_zero_b_o = mode_zero[1];
  assign mode_one_a_o  = mode_one[0];
  assign mode_one_b_o  = mode_one[1];
  assign mode_two_a_o  = mode_two[0];
  assign mode_two_b_o  = mode_two[1];

  //================================================================
  // Checks
  property p_ptr_reset;
    @(posedge clk_i) srst_i |=> mode_ptr[0] == PTR_ONE;
  endproperty
  a_ptr_reset: assert property (p_ptr_reset)
    else $error("pointer not one after reset");

  property p_ptr_zero;
    @(posedge clk_i) disable iff (srst_i)
      wr_i && addr_i == A_CMD_A && wdata_i[7:4] == CMD_PTR0
      |=> mode_ptr[0] == PTR_ZERO;
  endproperty
  a_ptr_zero: assert property (p_ptr_zero)
    else $error("pointer zero command ignored");

  property p_ptr_stop;
    @(posedge clk_i) disable iff (srst_i)
      mode_ptr[0] == PTR_TWO && !(wr_i && addr_i == A_CMD_A)
      |=> mode_ptr[0] == PTR_TWO;
  endproperty
  a_ptr_stop: assert property (p_ptr_stop)
    else $error("pointer left mode two");

  property p_set;
    @(posedge clk_i) disable iff (srst_i)
      wr_i && addr_i == A_OSET |=> (out_pin_o[7:2] & $past(wdata_i[7:2]))
      == $past(wdata_i[7:2]);
  endproperty
  a_set: assert property (p_set)
    else $error("output set failed");

  property p_clr;
    @(posedge clk_i) disable iff (srst_i)
      wr_i && addr_i == A_OCLR |=> (out_pin_o & $past(wdata_i)) == 8'h00;
  endproperty
  a_clr: assert property (p_clr)
    else $error("output clear failed");

  property p_keep;
    @(posedge clk_i) disable iff (srst_i)
      wr_i && addr_i == A_OSET |=>
        (out_pin_o[7:2] & ~$past(wdata_i[7:2]))
        == ($past(out_pin_o[7:2]) & ~$past(wdata_i[7:2]));
  endproperty
  a_keep: assert property (p_keep)
    else $error("unflagged output bit changed");

  property p_wd_off;
    @(posedge clk_i) disable iff (srst_i)
      !mode_zero[0][MZ_WDOG] |=> !wd_fired[0];
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("watchdog fired while off");

  property p_wd_rdy;
    @(posedge clk_i) disable iff (srst_i)
      wd_fired[0] && irq_mask[FL_RX_A] |=> irq_flags_o[FL_RX_A];
  endproperty
  a_wd_rdy: assert property (p_wd_rdy)
    else $error("watchdog not seen as rx ready");

  property p_access;
    @(posedge clk_i) disable iff (srst_i)
      (rd_i || wr_i) && addr_i == A_FIFO_A |=> wd_count[0] == '0;
  endproperty
  a_access: assert property (p_access)
    else $error("fifo access did not restart watchdog");
endmodule

// *** verilog/duart_pkg.sv ***
// Package for the dual channel serial controller register bank
//==================================================================
// Overview of operation
// - Mode zero bit 7 turns the receive idle watchdog off or on
// - Watchdog on: receive interrupt after 64 idle receive bit times
// - Watchdog expiry sets receiver ready in status and flag registers
// - Receive threshold code is mode zero bit 6 over mode one bit 6
// - After reset FIFO empty, threshold interrupts at one byte
// - Mode zero reached only after pointer-to-zero channel command
// - Output bits 1 and 0 are request-to-send, set and cleared by the host; mode one bit 7 drops them while receive FIFO full
// - Status bits: ready, full, tx ready, tx empty, errors, break
// - Command bits: rx en, rx dis, tx en, tx dis, code in 7..4
// - Each mask bit enables its interrupt source by fixed position
// - Flags share mask positions; bits 1 and 5 follow threshold
// - Timer divisor 16 bits from high and low preset registers
// - Aux control: baud set, counter mode, input change enables
// - Input change: deltas in 7..4, present levels in 3..0
// - Input level register returns input pins 7..0
// - Set register sets flagged output bits, clear clears them
// - Output configuration holds one bit per output pin
// - Clock select: receive code 7..4, transmit code 3..0
// - Mode zero: tx threshold 5..4, depth 3, baud ext 2,0, test 1
// - Mode one: rts ctl, rx thr low, err mode, parity, char length
// - Mode two: channel mode, tx rts, cts enable, stop length
// - Mode access advances pointer, stops at two, resets to one
// - Threshold codes mean 1,3,6,8 or 1,8,12,16 bytes by depth
package duart_pkg;
  // Register addresses, read and write views
  localparam logic [3:0] A_MODE_A   = 4'h0;
  localparam logic [3:0] A_STAT_A   = 4'h1;
  localparam logic [3:0] A_CMD_A    = 4'h2;
  localparam logic [3:0] A_FIFO_A   = 4'h3;
  localparam logic [3:0] A_CHG_AUX  = 4'h4;
  localparam logic [3:0] A_FLAG_MSK = 4'h5;
  localparam logic [3:0] A_TPH      = 4'h6;
  localparam logic [3:0] A_TPL      = 4'h7;
  localparam logic [3:0] A_MODE_B   = 4'h8;
  localparam logic [3:0] A_STAT_B   = 4'h9;
  localparam logic [3:0] A_CMD_B    = 4'hA;
  localparam logic [3:0] A_FIFO_B   = 4'hB;
  localparam logic [3:0] A_LVL_CFG  = 4'hD;
  localparam logic [3:0] A_OSET     = 4'hE;
  localparam logic [3:0] A_OCLR     = 4'hF;
  // Mode pointer values
  localparam logic [1:0] PTR_ZERO  = 2'h0;
  localparam logic [1:0] PTR_ONE   = 2'h1;
  localparam logic [1:0] PTR_TWO   = 2'h2;
  // Channel command codes for the pointer
  localparam logic [3:0] CMD_PTR1  = 4'h1;
  localparam logic [3:0] CMD_PTR0  = 4'hB;
  // Field positions
  localparam int MZ_WDOG   = 7;
  localparam int MZ_RXTHR  = 6;
  localparam int MZ_DEPTH  = 3;
  localparam int MO_RXTHR  = 6;
  localparam int MO_RXRTS  = 7;
  localparam int MT_TXRTS  = 5;
  localparam int CMD_RXEN  = 0;
  localparam int CMD_RXDIS = 1;
  localparam int CMD_TXEN  = 2;
  localparam int CMD_TXDIS = 3;
  localparam int ST_RX_READY = 0;
  localparam int ST_RX_FULL  = 1;
  localparam int ST_TX_READY = 2;
  localparam int ST_TX_EMPTY = 3;
  localparam int FL_RX_A   = 1;
  localparam int FL_RX_B   = 5;
  localparam int FL_TX_A   = 0;
  localparam int FL_TX_B   = 4;
  localparam int FL_CHG    = 7;
  // Reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  // Watchdog span in receive bit times
  localparam logic [6:0] WDOG_BITS = 7'h40;
  // Thresholds for an 8 byte FIFO, then a 16 byte FIFO
  localparam logic [4:0] THR8_0  = 5'h01;
  localparam logic [4:0] THR8_1  = 5'h03;
  localparam logic [4:0] THR8_2  = 5'h06;
  localparam logic [4:0] THR8_3  = 5'h08;
  localparam logic [4:0] THR16_0 = 5'h01;
  localparam logic [4:0] THR16_1 = 5'h08;
  localparam logic [4:0] THR16_2 = 5'h0C;
  localparam logic [4:0] THR16_3 = 5'h10;

  // Per-channel status inputs from the serial engine
  typedef struct packed {
    logic [3:0] errs;       // break, framing, parity, overrun
    logic       tx_empty;
    logic       tx_ready;
    logic [4:0] rx_count;   // bytes held in receive FIFO
    logic       rx_bit_tick;
  } duart_chan_in_t;
endpackage

// *** tb/duart_chan_model.sv ***
// Behavioural serial engine standing behind one channel of the bank
`timescale 1ns/1ps
module duart_chan_model
  import duart_pkg::*;
#(
  parameter int TICK_DIV = 4
)(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       load_i,
  input  wire logic [4:0] load_cnt_i,
  input  wire logic       pop_i,
  input  wire logic [3:0] errs_i,
  output duart_chan_in_t  chan_o
);
  logic [4:0] count;
  int         div;
  logic       tick;

  //==================================================================
  // Receive FIFO fill level
  // Bench loads a level directly; each pop takes one byte away
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count <= 5'h00;
    end else if (load_i) begin
      count <= load_cnt_i;
    end else if (pop_i && count != 5'h00) begin
      count <= count - 5'h01;
    end
  end

  // Receive 1x bit clock, free running like a real line clock
  always_ff @(posedge clk_i) begin
    if (srst_i || div == TICK_DIV - 1) begin
      div <= 0;
    end else begin
      div <= div + 1;
    end
  end

  // Transmitter always idle; keeps tx flags out of the way
  assign tick   = (div == TICK_DIV - 1);
  assign chan_o = '{errs: errs_i, tx_empty: 1'b1, tx_ready: 1'b1,
                    rx_count: count, rx_bit_tick: tick};
endmodule

// *** tb/duart_regs_tb.sv ***
// Self-checking testbench for the serial controller register bank
`timescale 1ns/1ps
module duart_regs_tb
  import duart_pkg::*;
;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       rd = 1'b0;
  logic       wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] in_pin = 8'h5A;
  logic       ctr_rdy = 1'b0;
  logic [1:0] brk_chg = 2'h0;
  logic       ld_a = 1'b0;
  logic [4:0] cnt_a = 5'h00;
  logic [3:0] errs_a = 4'h0;
  logic [7:0] rdata, out_pin, out_cfg, aux, flags;
  logic [7:0] mz_a, mz_b, mo_a, mo_b, mt_a, mt_b, cs_a, cs_b, d;
  logic [15:0] tdiv;
  logic [1:0] rx_en, tx_en, rx_pop, tx_push;
  logic [4:0] thr;
  duart_chan_in_t ch_a, ch_b;
  int n_errors = 0;
  int cmp_count = 0;

  //==================================================================
  // Clock, design and partner models
  always #12.5 clk = ~clk;

  duart_regs i_dut (.clk_i(clk), .srst_i(srst), .addr_i(addr),
    .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata),
    .chan_a_i(ch_a), .chan_b_i(ch_b), .ctr_ready_i(ctr_rdy),
    .break_chg_i(brk_chg), .in_pin_i(in_pin), .out_pin_o(out_pin),
    .out_config_o(out_cfg), .timer_div_o(tdiv), .aux_control_o(aux),
    .irq_flags_o(flags), .rx_en_o(rx_en), .tx_en_o(tx_en),
    .rx_pop_o(rx_pop), .tx_push_o(tx_push), .mode_zero_a_o(mz_a),
    .mode_zero_b_o(mz_b), .mode_one_a_o(mo_a), .mode_one_b_o(mo_b),
    .mode_two_a_o(mt_a), .mode_two_b_o(mt_b),
    .clock_select_a_o(cs_a), .clock_select_b_o(cs_b));

  duart_chan_model #(.TICK_DIV(4)) i_chan_a (.clk_i(clk), .srst_i(srst),
    .load_i(ld_a), .load_cnt_i(cnt_a), .pop_i(rx_pop[0]),
    .errs_i(errs_a), .chan_o(ch_a));
  duart_chan_model #(.TICK_DIV(4)) i_chan_b (.clk_i(clk), .srst_i(srst),
    .load_i(1'b0), .load_cnt_i(5'h00), .pop_i(rx_pop[1]),
    .errs_i(4'h0), .chan_o(ch_b));

  //==================================================================
  // Bus tasks and comparison
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  // Strobe raised after one edge, taken and dropped at the next;
  // one more edge lets the written register settle before checks
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a,
                        input logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    chk(what, {8'h00, e}, {8'h00, v});
  endtask

  // Pointer to zero, then the three mode registers in order
  task automatic set_modes(input logic [3:0] b, input logic [7:0] z,
                           input logic [7:0] o, input logic [7:0] t);
    wr_reg(b | A_CMD_A, {CMD_PTR0, 4'h0});
    wr_reg(b, z);
    wr_reg(b, o);
    wr_reg(b, t);
  endtask

  task automatic fill(input logic [4:0] n);
    @(posedge clk);
    ld_a <= 1'b1;
    cnt_a <= n;
    @(posedge clk);
    ld_a <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic rx_flag(input string what, input logic e);
    logic [7:0] v;
    rd_reg(A_FLAG_MSK, v);
    chk(what, {15'h0000, e}, {15'h0000, v[FL_RX_A]});
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard: a run that overstays counts as a mismatch
  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    conclude;
  end

  //==================================================================
  // Test sequence
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    // Pointer starts at mode one and stops at mode two
    rd_chk("status_idle", A_STAT_A, 8'h0C);
    wr_reg(A_MODE_A, 8'h11);
    wr_reg(A_MODE_A, 8'h22);
    wr_reg(A_MODE_A, 8'h33);
    chk("mode_one_a", 16'h0011, {8'h00, mo_a});
    chk("mode_two_a", 16'h0033, {8'h00, mt_a});
    chk("mode_zero_a", 16'h0000, {8'h00, mz_a});
    wr_reg(A_CMD_A, {CMD_PTR0, 4'h0});
    rd_chk("ptr_0", A_MODE_A, 8'h00);
    rd_chk("ptr_1", A_MODE_A, 8'h11);
    rd_chk("ptr_2", A_MODE_A, 8'h33);
    rd_chk("ptr_stop", A_MODE_A, 8'h33);
    wr_reg(A_CMD_A, {CMD_PTR1, 4'h0});
    rd_chk("ptr_cmd1", A_MODE_A, 8'h11);
    set_modes(A_MODE_B, 8'hC9, 8'h5A, 8'hA7);
    chk("mode_zero_b", 16'h00C9, {8'h00, mz_b});
    chk("mode_one_b", 16'h005A, {8'h00, mo_b});
    chk("mode_two_b", 16'h00A7, {8'h00, mt_b});
    $display("test pointer done");
    // Enable, disable and both at once, on each channel
    for (int c = 0; c < 2; c++) begin
      wr_reg(4'(c * 8) | A_CMD_A, 8'h05);
      chk("en", 16'h0003, {14'h0, rx_en[c], tx_en[c]});
      wr_reg(4'(c * 8) | A_CMD_A, 8'h0A);
      chk("dis", 16'h0000, {14'h0, rx_en[c], tx_en[c]});
      wr_reg(4'(c * 8) | A_CMD_A, 8'h05);
      wr_reg(4'(c * 8) | A_CMD_A, 8'h0F);
      chk("both", 16'h0000, {14'h0, rx_en[c], tx_en[c]});
      wr_reg(4'(c * 8) | A_STAT_A, 8'h5A + 8'(c));
    end
    chk("csel", 16'h5A5B, {cs_a, cs_b});
    $display("test command done");
    // Shared registers and output port
    wr_reg(A_TPH, 8'h12);
    wr_reg(A_TPL, 8'h34);
    chk("timer_div", 16'h1234, tdiv);
    wr_reg(A_CHG_AUX, 8'h9F);
    chk("aux", 16'h009F, {8'h00, aux});
    wr_reg(A_LVL_CFG, 8'h6C);
    chk("out_cfg", 16'h006C, {8'h00, out_cfg});
    wr_reg(A_OSET, 8'h3C);
    wr_reg(A_OSET, 8'h80);
    chk("out_set", 16'h00BC, {8'h00, out_pin});
    wr_reg(A_OCLR, 8'h14);
    chk("out_clr", 16'h00A8, {8'h00, out_pin});
    rd_chk("in_level", A_LVL_CFG, 8'h5A);
    rd_chk("unmapped_2", A_CMD_A, 8'h00);
    rd_chk("unmapped_c", 4'hC, 8'h00);
    rd_reg(A_CHG_AUX, d);
    in_pin <= 8'h5E;
    repeat (3) @(posedge clk);
    rd_chk("in_change", A_CHG_AUX, 8'h4E);
    rd_chk("in_change_clr", A_CHG_AUX, 8'h0E);
    $display("test shared done");
    // Every threshold code at both depths, just below and at level
    wr_reg(A_FLAG_MSK, 8'hFF);
    for (int k = 0; k < 8; k++) begin
      case (k)
        0, 4: thr = 5'h01;
        1: thr = 5'h03;
        2: thr = 5'h06;
        3, 5: thr = 5'h08;
        6: thr = 5'h0C;
        default: thr = 5'h10;
      endcase
      set_modes(A_MODE_A, {1'b0, k[1], 2'b00, k[2], 3'b000},
                {1'b0, k[0], 6'h00}, 8'h00);
      fill(thr - 5'h01);
      rx_flag("below_thr", 1'b0);
      fill(thr);
      rx_flag("at_thr", 1'b1);
    end
    $display("test threshold done");
    // Status with a full FIFO and errors, then masking
    set_modes(A_MODE_A, 8'h00, 8'h00, 8'h00);
    errs_a <= 4'hA;
    fill(5'h08);
    rd_chk("status_full", A_STAT_A, 8'hAF);
    errs_a <= 4'h0;
    wr_reg(A_FLAG_MSK, 8'h02);
    @(posedge clk);
    chk("irq_rx", 16'h0002, {8'h00, flags});
    ctr_rdy <= 1'b1;
    wr_reg(A_FLAG_MSK, 8'h08);
    @(posedge clk);
    chk("irq_ctr", 16'h0008, {8'h00, flags});
    wr_reg(A_FLAG_MSK, 8'h00);
    @(posedge clk);
    chk("irq_none", 16'h0000, {8'h00, flags});
    $display("test status done");
    // Idle watchdog: off, then on and restarted by a FIFO read
    set_modes(A_MODE_A, 8'h00, 8'h40, 8'h00);
    fill(5'h01);
    repeat (280) @(posedge clk);
    rx_flag("wdog_off", 1'b0);
    set_modes(A_MODE_A, 8'h80, 8'h40, 8'h00);
    fill(5'h02);
    rd_reg(A_FIFO_A, d);
    repeat (240) @(posedge clk);
    rx_flag("wdog_early", 1'b0);
    repeat (32) @(posedge clk);
    rx_flag("wdog_fire", 1'b1);
    rd_chk("wdog_status", A_STAT_A, 8'h0D);
    rd_reg(A_FIFO_A, d);
    rx_flag("wdog_clear", 1'b0);
    $display("test watchdog done");
    // Receiver rts drops output 0 only once the FIFO is full
    wr_reg(A_OSET, 8'h03);
    set_modes(A_MODE_A, 8'h00, 8'h80, 8'h00);
    fill(5'h07);
    chk("rts_below", 16'h00AB, {8'h00, out_pin});
    fill(5'h08);
    chk("rts_full", 16'h00AA, {8'h00, out_pin});
    wr_reg(A_FIFO_A, 8'h55);
    chk("tx_push", 16'h0001, {14'h0, tx_push});
    $display("test rts done");
    conclude;
  end
endmodule
